// [design/conv_regs_defs.vh]
// Register offsets, field positions, reset values and timing counts of the converter control bank.
`ifndef CONV_REGS_DEFS_VH
`define CONV_REGS_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_SETPOINT_LOW   8'h00
`define OFS_SETPOINT_HIGH  8'h01
`define OFS_APPLY_CONTROL  8'h02
`define OFS_CURRENT_LIMIT  8'h03
`define OFS_CONTROL_ONE    8'h04
`define OFS_CONTROL_TWO    8'h05
`define OFS_STATUS         8'h09

// ****************************************
// Slave addresses chosen by the strap level
// ****************************************
`define SLAVE_ADDR_RANGE0  7'h69
`define SLAVE_ADDR_RANGE1  7'h6B
`define SLAVE_ADDR_RANGE2  7'h6D
`define SLAVE_ADDR_RANGE3  7'h6F

// ****************************************
// Field positions
// ****************************************
`define APPLY_GO_BIT       0
`define APPLY_DELAY_BIT    1
`define CONTROL_ONE_ENABLE_BIT    7
`define CONTROL_ONE_FAULT_BIT     6
`define CONTROL_ONE_DISCHARGE_BIT 5
`define CONTROL_ONE_MODE_BIT      4
`define CONTROL_ONE_RATE_MSB      3
`define CONTROL_ONE_RATE_LSB      2
`define CONTROL_TWO_COMP_MSB      7
`define CONTROL_TWO_COMP_LSB      6
`define CONTROL_TWO_SOFT_MSB      5
`define CONTROL_TWO_SOFT_LSB      4
`define STAT_GOOD_BIT      7
`define STAT_THERMAL_BIT   6
`define STAT_WARN_BIT      5
`define STAT_MODE_BIT      4

// ****************************************
// Reset and fuse values
// ****************************************
`define RST_SETPOINT_CODE  11'h1F4
`define RST_CURRENT_LIMIT  7'h3C
`define MAX_CURRENT_LIMIT  7'h50
`define RST_CONTROL_ONE    8'hF0
`define RST_CONTROL_TWO    8'h30

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS      10
`define RAMP_STEP_NS       10000
`define RAMP_STEP_CYCLES   ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GOOD_DELAY_US      100
`define GOOD_DELAY_CYCLES  ((`GOOD_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [design/serial_byte_slave.v]
// Two-wire serial slave: framing, address match, register pointer, write strobe and read shifter.
`timescale 1ns/1ps
`default_nettype none

module serial_byte_slave
(
	input  wire       core_clk,
	input  wire       reset,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire [6:0] own_addr,
	output reg        wr_pulse,
	output reg  [7:0] wr_addr,
	output reg  [7:0] wr_data,
	output reg  [7:0] rd_addr,
	input  wire [7:0] rd_data
);

	localparam [2:0] ST_IDLE  = 3'd0;
	localparam [2:0] ST_ADDR  = 3'd1;
	localparam [2:0] ST_REG   = 3'd2;
	localparam [2:0] ST_WDATA = 3'd3;
	localparam [2:0] ST_RDATA = 3'd4;

	reg  [2:0] state;
	reg  [2:0] bit_cnt;
	reg        ack_phase;
	reg  [7:0] rx_shift;
	reg  [7:0] tx_shift;
	reg        scl_q;
	reg        sda_q;
	reg        first_fall;

	wire start_seen = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_seen  = scl_in & scl_q & ~sda_q & sda_in;
	wire scl_rise   = scl_in & ~scl_q;
	wire scl_fall   = ~scl_in & scl_q;

	always @(posedge core_clk)
	begin
		wr_pulse <= 1'b0;
		if (reset)
		begin
			state     <= ST_IDLE;
			bit_cnt   <= 3'd0;
			ack_phase <= 1'b0;
			rx_shift  <= 8'h00;
			tx_shift  <= 8'hFF;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			first_fall <= 1'b0;
			sda_out   <= 1'b0;
			sda_oe    <= 1'b0;
			wr_addr   <= 8'h00;
			wr_data   <= 8'h00;
			rd_addr   <= 8'h00;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			if (start_seen)
			begin
				state     <= ST_ADDR;
				bit_cnt   <= 3'd0;
				ack_phase <= 1'b0;
				sda_oe    <= 1'b0;
				first_fall <= 1'b1;
			end
			else if (stop_seen)
			begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end
			else if (state != ST_IDLE && scl_rise)
			begin
				if (ack_phase)
				begin
					// A master that does not acknowledge ends the read.
					if (state == ST_RDATA && sda_in)
						state <= ST_IDLE;
				end
				else
				begin
					rx_shift <= {rx_shift[6:0], sda_in};
					bit_cnt  <= bit_cnt + 3'd1;
				end
			end
			else if (state != ST_IDLE && scl_fall)
			begin
				// The fall that closes a start condition is no data clock, so it is skipped.
				if (first_fall)
					first_fall <= 1'b0;
				else if (ack_phase)
				begin
					ack_phase <= 1'b0;
					if (state == ST_RDATA)
					begin
						tx_shift <= rd_data;
						sda_oe   <= ~rd_data[7];
					end
					else
						sda_oe <= 1'b0;
				end
				else if (bit_cnt == 3'd0)
				begin
					ack_phase <= 1'b1;
					case (state)
						ST_ADDR:
						begin
							if (rx_shift[7:1] == own_addr)
							begin
								sda_oe <= 1'b1;
								state  <= rx_shift[0] ? ST_RDATA : ST_REG;
							end
							else
							begin
								ack_phase <= 1'b0;
								state     <= ST_IDLE;
							end
						end
						ST_REG:
						begin
							rd_addr <= rx_shift;
							sda_oe  <= 1'b1;
							state   <= ST_WDATA;
						end
						ST_WDATA:
						begin
							// The write lands on the falling edge of the last data bit.
							wr_pulse <= 1'b1;
							wr_addr  <= rd_addr;
							wr_data  <= rx_shift;
							rd_addr  <= rd_addr + 8'd1;
							sda_oe   <= 1'b1;
						end
						ST_RDATA:
						begin
							rd_addr <= rd_addr + 8'd1;
							sda_oe  <= 1'b0;
						end
						default:
							state <= ST_IDLE;
					endcase
				end
				else if (state == ST_RDATA)
				begin
					sda_oe   <= ~tx_shift[6];
					tx_shift <= {tx_shift[6:0], 1'b1};
				end
			end
		end
	end

endmodule // serial_byte_slave

`default_nettype wire

// [design/converter_control_registers.v]
// Control and status register bank of a buck-boost converter behind a two-wire serial port.
`timescale 1ns/1ps
`default_nettype none
`include "conv_regs_defs.vh"

module converter_control_registers
#(
	parameter integer GOOD_DELAY_CYCLES = `GOOD_DELAY_CYCLES,
	parameter integer RAMP_CYCLES       = `RAMP_STEP_CYCLES
)
(
	input  wire        core_clk,
	input  wire        reset,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output wire        sda_oe,
	input  wire        strap_above_quarter,
	input  wire        strap_above_half,
	input  wire        strap_above_three_quarter,
	input  wire        enable_pin,
	input  wire        vin_undervoltage,
	input  wire        thermal_shutdown,
	input  wire        thermal_warning_flag,
	input  wire        regulation_mode_flag,
	input  wire        output_in_regulation,
	output reg         converter_on,
	output reg         discharge_on,
	output reg  [10:0] reference_code,
	output reg  [6:0]  current_limit_code,
	output reg         forced_pwm,
	output reg  [1:0]  switch_rate_sel,
	output reg  [1:0]  drop_comp_sel,
	output reg  [1:0]  soft_start_sel,
	output reg         power_good_flag
);

	// ****************************************
	// Address strap
	// ****************************************
	function [6:0] strap_to_addr;
		input q1;
		input q2;
		input q3;
		begin
			if (q3)
				strap_to_addr = `SLAVE_ADDR_RANGE3;
			else if (q2)
				strap_to_addr = `SLAVE_ADDR_RANGE2;
			else if (q1)
				strap_to_addr = `SLAVE_ADDR_RANGE1;
			else
				strap_to_addr = `SLAVE_ADDR_RANGE0;
		end
	endfunction

	reg        shutdown;
	reg        strap_taken;
	reg  [6:0] own_addr;

	// The strap is re-read while the port is down, so a changed divider counts after shutdown.
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			strap_taken <= 1'b0;
			own_addr    <= `SLAVE_ADDR_RANGE0;
		end
		else if (!strap_taken || shutdown)
		begin
			strap_taken <= 1'b1;
			own_addr    <= strap_to_addr(strap_above_quarter, strap_above_half,
				strap_above_three_quarter);
		end
	end

	// ****************************************
	// Shutdown and serial engine
	// ****************************************
	always @(posedge core_clk)
	begin
		if (reset)
			shutdown <= 1'b1;
		else
			shutdown <= ~enable_pin | vin_undervoltage;
	end

	wire       wr_pulse;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire [7:0] rd_addr;
	reg  [7:0] rd_data;

	serial_byte_slave port_engine
	(
		.core_clk (core_clk),
		.reset    (reset | shutdown),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.own_addr (own_addr),
		.wr_pulse (wr_pulse),
		.wr_addr  (wr_addr),
		.wr_data  (wr_data),
		.rd_addr  (rd_addr),
		.rd_data  (rd_data)
	);

	// ****************************************
	// Fuse image
	// ****************************************
	// Sized copies of the reload values, so that each field takes exactly its own bits.
	// A shutdown pulls these back in, which overrides anything the host wrote.
	localparam [10:0] FUSE_SETPOINT    = `RST_SETPOINT_CODE;
	localparam [7:0]  FUSE_CONTROL_ONE = `RST_CONTROL_ONE;
	localparam [7:0]  FUSE_CONTROL_TWO = `RST_CONTROL_TWO;

	// ****************************************
	// Control registers
	// ****************************************
	reg  [2:0]  setpoint_low_reg;
	reg  [7:0]  setpoint_high_reg;
	reg         good_flag_delay_sel;
	reg  [6:0]  limit_reg;
	reg         enable_bit;
	reg         fault_mode_bit;
	reg         discharge_bit;
	reg         mode_bit;
	reg  [1:0]  rate_field;
	reg  [1:0]  comp_field;
	reg  [1:0]  soft_field;

	wire [10:0] setpoint_code = {setpoint_high_reg, setpoint_low_reg};

	// Disabling through the enable bit leaves every field alone; only a pin or
	// undervoltage shutdown pulls the fuse image back in.
	always @(posedge core_clk)
	begin
		if (reset || shutdown)
		begin
			setpoint_high_reg   <= FUSE_SETPOINT[10:3];
			setpoint_low_reg    <= FUSE_SETPOINT[2:0];
			good_flag_delay_sel <= 1'b0;
			limit_reg           <= `RST_CURRENT_LIMIT;
			enable_bit          <= FUSE_CONTROL_ONE[`CONTROL_ONE_ENABLE_BIT];
			fault_mode_bit      <= FUSE_CONTROL_ONE[`CONTROL_ONE_FAULT_BIT];
			discharge_bit       <= FUSE_CONTROL_ONE[`CONTROL_ONE_DISCHARGE_BIT];
			mode_bit            <= FUSE_CONTROL_ONE[`CONTROL_ONE_MODE_BIT];
			rate_field          <= FUSE_CONTROL_ONE[`CONTROL_ONE_RATE_MSB:`CONTROL_ONE_RATE_LSB];
			comp_field          <= FUSE_CONTROL_TWO[`CONTROL_TWO_COMP_MSB:`CONTROL_TWO_COMP_LSB];
			soft_field          <= FUSE_CONTROL_TWO[`CONTROL_TWO_SOFT_MSB:`CONTROL_TWO_SOFT_LSB];
		end
		else if (wr_pulse)
		begin
			case (wr_addr)
				`OFS_SETPOINT_LOW:
					setpoint_low_reg <= wr_data[2:0];
				`OFS_SETPOINT_HIGH:
					setpoint_high_reg <= wr_data;
				`OFS_APPLY_CONTROL:
					good_flag_delay_sel <= wr_data[`APPLY_DELAY_BIT];
				`OFS_CURRENT_LIMIT:
				begin
					// Codes above the top of the range are held at the top.
					if (wr_data[6:0] > `MAX_CURRENT_LIMIT)
						limit_reg <= `MAX_CURRENT_LIMIT;
					else
						limit_reg <= wr_data[6:0];
				end
				`OFS_CONTROL_ONE:
				begin
					enable_bit     <= wr_data[`CONTROL_ONE_ENABLE_BIT];
					fault_mode_bit <= wr_data[`CONTROL_ONE_FAULT_BIT];
					discharge_bit  <= wr_data[`CONTROL_ONE_DISCHARGE_BIT];
					mode_bit       <= wr_data[`CONTROL_ONE_MODE_BIT];
					rate_field     <= wr_data[`CONTROL_ONE_RATE_MSB:`CONTROL_ONE_RATE_LSB];
				end
				`OFS_CONTROL_TWO:
				begin
					comp_field <= wr_data[`CONTROL_TWO_COMP_MSB:`CONTROL_TWO_COMP_LSB];
					soft_field <= wr_data[`CONTROL_TWO_SOFT_MSB:`CONTROL_TWO_SOFT_LSB];
				end
				default:
					comp_field <= comp_field;
			endcase
		end
	end

	// ****************************************
	// Setpoint apply and reference ramp
	// ****************************************
	// Writing zero to the apply bit does not stop a ramp that is under way.
	reg         go_bit;
	reg  [10:0] target_code;
	reg  [15:0] ramp_cnt;

	wire go_write = wr_pulse && (wr_addr == `OFS_APPLY_CONTROL) && wr_data[`APPLY_GO_BIT];
	wire reached  = (reference_code == target_code);

	// A new apply that lands in the cycle the old one finishes keeps the bit set.
	always @(posedge core_clk)
	begin
		if (reset || shutdown)
		begin
			go_bit         <= 1'b0;
			target_code    <= `RST_SETPOINT_CODE;
			reference_code <= `RST_SETPOINT_CODE;
			ramp_cnt       <= 16'd0;
		end
		else if (go_write)
		begin
			go_bit      <= 1'b1;
			target_code <= setpoint_code;
			ramp_cnt    <= 16'd0;
		end
		else if (go_bit)
		begin
			if (reached)
				go_bit <= 1'b0;
			else if (ramp_cnt == RAMP_CYCLES[15:0] - 16'd1)
			begin
				ramp_cnt <= 16'd0;
				if (reference_code < target_code)
					reference_code <= reference_code + 11'd1;
				else
					reference_code <= reference_code - 11'd1;
			end
			else
				ramp_cnt <= ramp_cnt + 16'd1;
		end
	end

	// ****************************************
	// Power-good qualification
	// ****************************************
	// The count rests at its end value, so the flag stays up until regulation is lost.
	reg [15:0] good_cnt;

	always @(posedge core_clk)
	begin
		if (reset)
		begin
			good_cnt        <= 16'd0;
			power_good_flag <= 1'b0;
		end
		else if (!output_in_regulation)
		begin
			good_cnt        <= 16'd0;
			power_good_flag <= 1'b0;
		end
		else if (!good_flag_delay_sel)
			power_good_flag <= 1'b1;
		else if (good_cnt == GOOD_DELAY_CYCLES[15:0] - 16'd1)
			power_good_flag <= 1'b1;
		else
			good_cnt <= good_cnt + 16'd1;
	end

	// ****************************************
	// Converter-facing outputs
	// ****************************************
	always @(posedge core_clk)
	begin
		if (reset)
		begin
			converter_on       <= 1'b0;
			discharge_on       <= 1'b0;
			current_limit_code <= `RST_CURRENT_LIMIT;
			forced_pwm         <= 1'b1;
			switch_rate_sel    <= 2'b00;
			drop_comp_sel      <= 2'b00;
			soft_start_sel     <= 2'b11;
		end
		else
		begin
			converter_on       <= ~shutdown & enable_bit & ~thermal_shutdown;
			discharge_on       <= go_bit | (discharge_bit & shutdown);
			current_limit_code <= limit_reg;
			forced_pwm         <= mode_bit;
			switch_rate_sel    <= rate_field;
			drop_comp_sel      <= comp_field;
			soft_start_sel     <= soft_field;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	// Thermal and mode status come straight from the live inputs and power good from its flag register, so a read sees the state of that moment.
	always @*
	begin
		case (rd_addr)
			`OFS_SETPOINT_LOW:
				rd_data = {5'h00, setpoint_low_reg};
			`OFS_SETPOINT_HIGH:
				rd_data = setpoint_high_reg;
			`OFS_APPLY_CONTROL:
				rd_data = {6'h00, good_flag_delay_sel, go_bit};
			`OFS_CURRENT_LIMIT:
				rd_data = {1'b0, limit_reg};
			`OFS_CONTROL_ONE:
				rd_data = {enable_bit, fault_mode_bit, discharge_bit, mode_bit, rate_field, 2'b00};
			`OFS_CONTROL_TWO:
				rd_data = {comp_field, soft_field, 4'h0};
			`OFS_STATUS:
				rd_data = {power_good_flag, thermal_shutdown, thermal_warning_flag,
					regulation_mode_flag, 4'h0};
			default:
				rd_data = 8'h00;
		endcase
	end

endmodule // converter_control_registers

`default_nettype wire

// [test/conv_regs_asserts.sv]
// Concurrent checks on the port behaviour of the converter register bank.
`timescale 1ns/1ps
`default_nettype none
module conv_regs_checker
#(
	parameter integer RAMP_CYCLES = 4
)
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        enable_pin,
	input wire logic        thermal_shutdown,
	input wire logic        output_in_regulation,
	input wire logic        sda_oe,
	input wire logic        converter_on,
	input wire logic        discharge_on,
	input wire logic [10:0] reference_code,
	input wire logic [6:0]  current_limit_code,
	input wire logic        forced_pwm,
	input wire logic [1:0]  soft_start_sel,
	input wire logic        power_good_flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [10:0] ref_q;
	logic [15:0] gap;
	wire step = (reference_code == ref_q + 11'h1) || (ref_q == reference_code + 11'h1);
	// The gap counter saturates so that a long quiet spell never wraps into a false step.
	always_ff @(posedge core_clk)
	begin
		ref_q <= reference_code;
		if (reset || reference_code != ref_q)
			gap <= 16'h0;
		else if (gap != 16'hFFFF)
			gap <= gap + 16'h1;
	end
	a_ramp_rate: assert property (step |-> gap >= RAMP_CYCLES - 1)
		else $error("reference stepped too soon");
	a_ramp_discharge: assert property (step |-> discharge_on)
		else $error("discharge off while ramping");
	a_limit_cap: assert property (current_limit_code <= 7'h50)
		else $error("current limit above cap");
	a_reset_values: assert property ($fell(reset) |-> reference_code == 11'h1F4
		&& current_limit_code == 7'h3C && forced_pwm && soft_start_sel == 2'b11 && !converter_on)
		else $error("wrong values after reset");
	a_pin_off: assert property (!enable_pin |-> ##2 !converter_on && !sda_oe)
		else $error("active while enable pin low");
	a_pin_discharge: assert property (!enable_pin [*4] |-> discharge_on)
		else $error("no discharge in shutdown");
	a_thermal_off: assert property (thermal_shutdown |=> !converter_on)
		else $error("converter on in thermal shutdown");
	a_good_fall: assert property (!output_in_regulation |=> !power_good_flag)
		else $error("power good not dropped");
	a_good_cause: assert property ($rose(power_good_flag) |-> $past(output_in_regulation))
		else $error("power good rose without cause");
endmodule // conv_regs_checker
bind converter_control_registers conv_regs_checker #(.RAMP_CYCLES(RAMP_CYCLES)) i_chk
(
	.core_clk             (core_clk),
	.reset                (reset),
	.enable_pin           (enable_pin),
	.thermal_shutdown     (thermal_shutdown),
	.output_in_regulation (output_in_regulation),
	.sda_oe               (sda_oe),
	.converter_on         (converter_on),
	.discharge_on         (discharge_on),
	.reference_code       (reference_code),
	.current_limit_code   (current_limit_code),
	.forced_pwm           (forced_pwm),
	.soft_start_sel       (soft_start_sel),
	.power_good_flag      (power_good_flag)
);
`default_nettype wire

// [test/serial_host_model.sv]
// Two-wire bus master model driving the serial port of the register bank.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
(
	input wire logic core_clk,
	input wire logic sda_line,
	output logic     scl,
	output logic     sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic half;
		repeat (8) @(negedge core_clk);
	endtask
	task automatic start;
		half;
		sda_drv = 1'b1;
		half;
		scl = 1'b1;
		half;
		sda_drv = 1'b0;
		half;
		scl = 1'b0;
	endtask
	task automatic stop;
		half;
		sda_drv = 1'b0;
		half;
		scl = 1'b1;
		half;
		sda_drv = 1'b1;
		half;
	endtask
	// Data moves a half phase after the clock fell, well clear of the slave's sampling.
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			half;
			sda_drv = d[i];
			half;
			scl = 1'b1;
			half;
			q[i] = sda_line;
			scl = 1'b0;
		end
	endtask
endmodule // serial_host_model
`default_nettype wire

// [test/converter_control_registers_tb.sv]
// Self-checking bench for the converter register bank driven by a bus master model.
`timescale 1ns/1ps
`default_nettype none
module converter_control_registers_tb;
	logic core_clk, reset, enable_pin, vin_undervoltage, thermal_shutdown;
	logic strap_above_quarter, strap_above_half, strap_above_three_quarter;
	logic thermal_warning_flag, regulation_mode_flag, output_in_regulation;
	wire scl_in, sda_drv, sda_out, sda_oe, converter_on, discharge_on;
	wire forced_pwm, power_good_flag;
	wire [10:0] reference_code;
	wire [6:0] current_limit_code;
	wire [1:0] switch_rate_sel, drop_comp_sel, soft_start_sel;
	wire sda_in = sda_drv & ~(sda_oe & ~sda_out);
	logic [6:0] addr;
	logic [6:0] own_addr [4] = '{7'h69, 7'h6B, 7'h6D, 7'h6F};
	logic [2:0] strap_lvl [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
	int miscompares, checked, cycles;
	converter_control_registers #(.GOOD_DELAY_CYCLES(20), .RAMP_CYCLES(4)) i_dut
	(
		.core_clk                  (core_clk),
		.reset                     (reset),
		.scl_in                    (scl_in),
		.sda_in                    (sda_in),
		.sda_out                   (sda_out),
		.sda_oe                    (sda_oe),
		.strap_above_quarter       (strap_above_quarter),
		.strap_above_half          (strap_above_half),
		.strap_above_three_quarter (strap_above_three_quarter),
		.enable_pin                (enable_pin),
		.vin_undervoltage          (vin_undervoltage),
		.thermal_shutdown          (thermal_shutdown),
		.thermal_warning_flag      (thermal_warning_flag),
		.regulation_mode_flag      (regulation_mode_flag),
		.output_in_regulation      (output_in_regulation),
		.converter_on              (converter_on),
		.discharge_on              (discharge_on),
		.reference_code            (reference_code),
		.current_limit_code        (current_limit_code),
		.forced_pwm                (forced_pwm),
		.switch_rate_sel           (switch_rate_sel),
		.drop_comp_sel             (drop_comp_sel),
		.soft_start_sel            (soft_start_sel),
		.power_good_flag           (power_good_flag)
	);
	serial_host_model i_host (.core_clk(core_clk), .sda_line(sda_in), .scl(scl_in),
		.sda_drv(sda_drv));
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
		logic [8:0] q1, q2, q3;
		i_host.start;
		i_host.xfer({addr, 2'b01}, q1);
		i_host.xfer({ofs, 1'b1}, q2);
		i_host.xfer({data, 1'b1}, q3);
		i_host.stop;
		chk("write ack", 11'h0, {q1[0], q2[0], q3[0]});
	endtask
	task automatic rchk(input string what, input logic [7:0] ofs, input logic [7:0] exp);
		logic [8:0] q;
		i_host.start;
		i_host.xfer({addr, 2'b01}, q);
		i_host.xfer({ofs, 1'b1}, q);
		i_host.start;
		i_host.xfer({addr, 2'b11}, q);
		i_host.xfer(9'h1FF, q);
		i_host.stop;
		chk(what, {3'h0, exp}, {3'h0, q[8:1]});
	endtask
	task automatic t_defaults;
		chk("limit", 11'h3C, current_limit_code);
		chk("fields", 11'h87, {forced_pwm, switch_rate_sel, drop_comp_sel, soft_start_sel,
			converter_on});
		chk("reference", 11'h1F4, reference_code);
		rchk("control one", 8'h04, 8'hF0);
		rchk("control two", 8'h05, 8'h30);
		rchk("apply", 8'h02, 8'h00);
	endtask
	task automatic t_setpoint;
		wr(8'h00, 8'hFC);
		wr(8'h01, 8'h00);
		rchk("low byte", 8'h00, 8'h04);
		chk("held", 11'h1F4, reference_code);
		wr(8'h02, 8'h01);
		chk("discharge", 11'h1, discharge_on);
		rchk("go busy", 8'h02, 8'h01);
		for (int i = 0; i < 3000 && reference_code !== 11'h004; i++)
			tick(1);
		tick(3);
		chk("reference", 11'h004, reference_code);
		chk("discharge", 11'h0, discharge_on);
		rchk("go done", 8'h02, 8'h00);
	endtask
	task automatic t_limit;
		wr(8'h03, 8'h3D);
		tick(3);
		chk("limit out", 11'h3D, current_limit_code);
		wr(8'h03, 8'h7F);
		rchk("limit cap", 8'h03, 8'h50);
		wr(8'h04, 8'h70);
		tick(3);
		chk("off by bit", 11'h0, converter_on);
		rchk("limit kept", 8'h03, 8'h50);
		wr(8'h04, 8'hC4);
		tick(3);
		chk("mode rate", 11'h9, {converter_on, forced_pwm, switch_rate_sel});
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h05, {i[1:0], ~i[1:0], 4'h0});
			tick(3);
			chk("comp soft", {7'h0, i[1:0], ~i[1:0]}, {drop_comp_sel, soft_start_sel});
		end
	endtask
	task automatic t_status;
		thermal_warning_flag = 1'b1;
		regulation_mode_flag = 1'b1;
		output_in_regulation = 1'b1;
		rchk("status", 8'h09, 8'hB0);
		thermal_warning_flag = 1'b0;
		rchk("status live", 8'h09, 8'h90);
		thermal_shutdown = 1'b1;
		rchk("thermal", 8'h09, 8'hD0);
		chk("thermal off", 11'h0, converter_on);
		thermal_shutdown = 1'b0;
		wr(8'h02, 8'h02);
		output_in_regulation = 1'b0;
		tick(2);
		output_in_regulation = 1'b1;
		tick(19);
		chk("good early", 11'h0, power_good_flag);
		tick(3);
		chk("good late", 11'h1, power_good_flag);
	endtask
	task automatic t_shutdown;
		logic [8:0] q;
		wr(8'h04, 8'hF0);
		enable_pin = 1'b0;
		tick(4);
		chk("pin off", 11'h1, {converter_on, discharge_on});
		i_host.start;
		i_host.xfer({addr, 2'b01}, q);
		i_host.stop;
		chk("dead port", 11'h1, q[0]);
		enable_pin = 1'b1;
		tick(4);
		rchk("reloaded", 8'h03, 8'h3C);
		wr(8'h05, 8'h00);
		vin_undervoltage = 1'b1;
		tick(4);
		vin_undervoltage = 1'b0;
		tick(4);
		rchk("uv reload", 8'h05, 8'h30);
	endtask
	task automatic t_address;
		logic [8:0] q;
		for (int i = 0; i < 4; i++)
		begin
			enable_pin = 1'b0;
			{strap_above_three_quarter, strap_above_half, strap_above_quarter} = strap_lvl[i];
			tick(4);
			enable_pin = 1'b1;
			tick(4);
			addr = own_addr[i] ^ 7'h02;
			i_host.start;
			i_host.xfer({addr, 2'b01}, q);
			i_host.stop;
			chk("foreign addr", 11'h1, q[0]);
			addr = own_addr[i];
			rchk("own addr", 8'h03, 8'h3C);
		end
	endtask
	task automatic summarize;
		$display("checked %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// The ceiling sits near twice the expected run so a stuck handshake cannot hang it.
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			miscompares++;
			summarize;
		end
	end
	initial
	begin
		reset = 1'b1;
		enable_pin = 1'b1;
		vin_undervoltage = 1'b0;
		thermal_shutdown = 1'b0;
		{strap_above_three_quarter, strap_above_half, strap_above_quarter} = 3'h0;
		thermal_warning_flag = 1'b0;
		regulation_mode_flag = 1'b0;
		output_in_regulation = 1'b0;
		addr = 7'h69;
		tick(6);
		reset = 1'b0;
		tick(4);
		t_defaults;
		t_setpoint;
		t_limit;
		t_status;
		t_shutdown;
		t_address;
		summarize;
	end
endmodule // converter_control_registers_tb
`default_nettype wire
